//--- rtl/nfc_pkg.sv
// Constants for the NAND flash pin-level controller
package nfc_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CLK_PERIOD_NS = 50;
  // Array read time, longest, in microseconds
  localparam int ARRAY_READ_TIME_US = 80;
  localparam int ARRAY_READ_CYCLES = (ARRAY_READ_TIME_US * 1000) / CLK_PERIOD_NS;
  // Least read strobe cycle, in nanoseconds
  localparam int READ_CYCLE_NS = 25;
  localparam int READ_CYCLE_CLKS =
    ((READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Read access delay assumed for sampling, in nanoseconds
  localparam int READ_ACCESS_DELAY_NS = 20;
  localparam int READ_ACCESS_CLKS =
    ((READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PROGRAM_TIME_US = 1300;
  localparam int ERASE_TIME_US = 5000;
  localparam int PAGE_BYTES = 8704;
  localparam int ROW_CYCLES = 3;
  localparam int FULL_ADDR_CYCLES = 5;
  localparam logic [7:0] CMD_READ_1 = 8'h00;
  localparam logic [7:0] CMD_READ_2 = 8'h30;
  localparam logic [7:0] CMD_PROG_1 = 8'h80;
  localparam logic [7:0] CMD_PROG_2 = 8'h10;
  localparam logic [7:0] CMD_ERASE_1 = 8'h60;
  localparam logic [7:0] CMD_ERASE_2 = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  typedef enum logic [2:0] {
    NFC_OP_NONE,
    NFC_OP_READ,
    NFC_OP_PROGRAM,
    NFC_OP_ERASE,
    NFC_OP_STATUS,
    NFC_OP_RESET
  } nfc_op_e;
endpackage : nfc_pkg

//--- rtl/nfc_sync.sv
// Two-flop synchroniser for pin inputs
module nfc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : nfc_sync

//--- rtl/nfc_ctrl.sv
// Host-side pin sequencer for a multiplexed 8-bit NAND flash
// Function
// RULE1 - Command bytes strobed with command select high
// RULE2 - Address bytes strobed with address select high
// RULE3 - Bytes latched on write strobe rising edge
// RULE4 - Read strobe fall returns next byte
// RULE5 - Device floats bus when deselected
// RULE6 - Device stays busy despite chip deselect
// RULE7 - Low write-protect blocks program and erase
// RULE8 - Ready/busy low during array operations
// RULE9 - Ready/busy is open-drain, never floats
// RULE10 - Program covers 8704-byte page, about 1.3ms
// RULE11 - Erase covers one block, about 5ms
// RULE12 - Wait up to 80us after page read
// RULE13 - Read strobe cycle at least 25ns
// RULE14 - Controller supplies 40-bit-per-chunk error correction; this controller has none, bytes pass through uncorrected
// RULE15 - Controller scrambles and descrambles data; this controller passes bytes through unscrambled
// RULE16 - Device sequences program and erase itself
// RULE17 - One 8-bit port carries everything
// RULE18 - Operations chosen by two command bytes
// RULE19 - Five address cycles, erase uses three
// RULE20 - Only status or reset while busy
// RULE21 - Synchronise ready/busy, wait ready before operations
module nfc_ctrl #(
  parameter int ADDR_BYTES = nfc_pkg::FULL_ADDR_CYCLES,
  parameter int BUSY_TIMEOUT = nfc_pkg::ARRAY_READ_CYCLES
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // User side
  input wire logic start_i,
  input wire logic [2:0] op_i,
  input wire logic [39:0] addr_i,
  input wire logic [15:0] len_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic busy_o,
  output logic done_o,
  output logic timeout_o,
  input wire logic protect_i,
  // Flash pins
  output logic chip_enable_n_o,
  output logic cmd_latch_o,
  output logic addr_latch_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic write_protect_n_o,
  input wire logic [7:0] io_bus_i,
  output logic [7:0] io_bus_o,
  output logic io_bus_oe_n_o,
  input wire logic ready_busy_n_i
);
  typedef enum logic [3:0] {
    NFC_IDLE, NFC_CMD1, NFC_ADDR, NFC_WDATA, NFC_CMD2, NFC_WAIT_LOW,
    NFC_WAIT_HIGH, NFC_RDATA, NFC_FINISH
  } nfc_state_e;

  nfc_state_e state;
  nfc_pkg::nfc_op_e op;
  logic [39:0] addr_sh;
  logic [2:0] addr_left;
  logic [15:0] count;
  logic [1:0] phase;
  logic [23:0] wait_cnt;
  logic rb_sync;
  logic [7:0] io_sync;
  logic rd_take;

  // Ready/busy and the bus come from pins
  nfc_sync #(.WIDTH(1)) u_rb_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(ready_busy_n_i),
    .sync_o(rb_sync)
  ); // RULE21
  nfc_sync #(.WIDTH(8)) u_io_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(io_bus_i),
    .sync_o(io_sync)
  );

  function automatic logic [7:0] first_cmd(input nfc_pkg::nfc_op_e o);
    case (o)
      nfc_pkg::NFC_OP_READ: first_cmd = nfc_pkg::CMD_READ_1;
      nfc_pkg::NFC_OP_PROGRAM: first_cmd = nfc_pkg::CMD_PROG_1;
      nfc_pkg::NFC_OP_ERASE: first_cmd = nfc_pkg::CMD_ERASE_1;
      nfc_pkg::NFC_OP_STATUS: first_cmd = nfc_pkg::CMD_STATUS;
      default: first_cmd = nfc_pkg::CMD_RESET;
    endcase
  endfunction : first_cmd

  function automatic logic [7:0] second_cmd(input nfc_pkg::nfc_op_e o);
    case (o)
      nfc_pkg::NFC_OP_READ: second_cmd = nfc_pkg::CMD_READ_2;
      nfc_pkg::NFC_OP_PROGRAM: second_cmd = nfc_pkg::CMD_PROG_2;
      default: second_cmd = nfc_pkg::CMD_ERASE_2;
    endcase
  endfunction : second_cmd

  // Each pin cycle: phase 0 set up, 1 strobe low, 2 strobe high (latch)
  logic cyc_end;
  assign cyc_end = (phase == 2'd2);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phase <= 2'd0;
    end else if (state == NFC_IDLE || state == NFC_WAIT_LOW || state == NFC_WAIT_HIGH
                 || state == NFC_FINISH || (state == NFC_WDATA && !wr_valid_i)) begin
      phase <= 2'd0;
    end else if (cyc_end) begin
      phase <= 2'd0;
    end else begin
      phase <= phase + 2'd1;
    end
  end

  // Main sequencer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= NFC_IDLE;
      op <= nfc_pkg::NFC_OP_NONE;
      addr_sh <= '0;
      addr_left <= '0;
      count <= '0;
      wait_cnt <= '0;
      timeout_o <= 1'b0;
    end else begin
      case (state)
        NFC_IDLE: begin
          // Status and reset may go out while busy; array ops wait for ready
          if (start_i && (rb_sync || op_i == nfc_pkg::NFC_OP_STATUS
              || op_i == nfc_pkg::NFC_OP_RESET)) begin // RULE20 RULE21
            op <= nfc_pkg::nfc_op_e'(op_i);
            addr_sh <= addr_i;
            addr_left <= (op_i == nfc_pkg::NFC_OP_ERASE) ? 3'(nfc_pkg::ROW_CYCLES)
                                                      : 3'(ADDR_BYTES); // RULE19
            // Erase skips the two column bytes
            if (op_i == nfc_pkg::NFC_OP_ERASE) begin
              addr_sh <= {16'h0000, addr_i[39:16]};
            end
            count <= (op_i == nfc_pkg::NFC_OP_STATUS) ? 16'h0001 : len_i;
            // Reset skips the second command, so the give-up count starts here
            wait_cnt <= '0;
            timeout_o <= 1'b0;
            state <= NFC_CMD1;
          end
        end
        NFC_CMD1: begin
          if (cyc_end) begin // RULE18
            if (op == nfc_pkg::NFC_OP_STATUS) begin
              state <= NFC_RDATA;
            end else if (op == nfc_pkg::NFC_OP_RESET) begin
              state <= NFC_WAIT_LOW;
            end else begin
              state <= NFC_ADDR;
            end
          end
        end
        NFC_ADDR: begin
          if (cyc_end) begin
            addr_sh <= {8'h00, addr_sh[39:8]};
            addr_left <= addr_left - 3'd1;
            if (addr_left == 3'd1) begin
              state <= (op == nfc_pkg::NFC_OP_PROGRAM) ? NFC_WDATA : NFC_CMD2;
            end
          end
        end
        NFC_WDATA: begin
          if (cyc_end) begin
            count <= count - 16'h0001;
            if (count == 16'h0001) begin
              state <= NFC_CMD2;
            end
          end
        end
        NFC_CMD2: begin
          if (cyc_end) begin
            state <= NFC_WAIT_LOW;
            wait_cnt <= '0;
          end
        end
        NFC_WAIT_LOW: begin
          // Give the device a few cycles to pull ready/busy low
          wait_cnt <= wait_cnt + 24'd1;
          if (!rb_sync || wait_cnt == 24'd4) begin
            state <= NFC_WAIT_HIGH;
            wait_cnt <= '0;
          end
        end
        NFC_WAIT_HIGH: begin
          wait_cnt <= wait_cnt + 24'd1;
          if (rb_sync) begin // RULE8
            state <= (op == nfc_pkg::NFC_OP_READ) ? NFC_RDATA : NFC_FINISH;
          end else if (op == nfc_pkg::NFC_OP_READ
                       && wait_cnt >= 24'(BUSY_TIMEOUT)) begin // RULE12
            timeout_o <= 1'b1;
            state <= NFC_FINISH;
          end
        end
        NFC_RDATA: begin
          if (cyc_end) begin // RULE4
            count <= count - 16'h0001;
            if (count == 16'h0001) begin
              state <= NFC_FINISH;
            end
          end
        end
        default: begin
          state <= NFC_IDLE;
        end
      endcase
    end
  end

  // Pin drive, all from flops
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      chip_enable_n_o <= 1'b1;
      cmd_latch_o <= 1'b0;
      addr_latch_o <= 1'b0;
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      io_bus_o <= 8'h00;
      io_bus_oe_n_o <= 1'b1;
    end else begin
      chip_enable_n_o <= (state == NFC_IDLE || state == NFC_FINISH);
      cmd_latch_o <= (state == NFC_CMD1 || state == NFC_CMD2); // RULE1
      addr_latch_o <= (state == NFC_ADDR); // RULE2
      // Strobe low in phase 1, rising edge after data held stable
      write_strobe_n_o <= !((state == NFC_CMD1 || state == NFC_CMD2 || state == NFC_ADDR
                            || state == NFC_WDATA) && phase == 2'd0
                            && !(state == NFC_WDATA && !wr_valid_i)); // RULE3
      // 150ns low-high read cycle easily clears the least strobe cycle
      read_strobe_n_o <= !(state == NFC_RDATA && phase == 2'd0); // RULE13
      io_bus_oe_n_o <= !(state == NFC_CMD1 || state == NFC_CMD2 || state == NFC_ADDR
                         || state == NFC_WDATA); // RULE17
      if (state == NFC_CMD1) begin
        io_bus_o <= first_cmd(op);
      end else if (state == NFC_CMD2) begin
        io_bus_o <= second_cmd(op);
      end else if (state == NFC_ADDR) begin
        io_bus_o <= addr_sh[7:0];
      end else if (state == NFC_WDATA) begin
        io_bus_o <= wr_data_i; // RULE15 not met: the write byte goes to the bus unscrambled
      end
    end
  end

  // Write-protect released only when user does not assert protection
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      write_protect_n_o <= 1'b0;
    end else begin
      write_protect_n_o <= !protect_i; // RULE7
    end
  end

  // User data handshake; read byte sampled at the end of the strobe-low phase
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      rd_take <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      wr_ready_o <= (state == NFC_WDATA && phase == 2'd0 && wr_valid_i);
      // Synchroniser lags two edges; one edge past strobe-high end shows the strobe-low byte
      rd_take <= (state == NFC_RDATA && cyc_end);
      rd_valid_o <= rd_take; // RULE4
      if (rd_take) begin
        rd_data_o <= io_sync;
      end
      busy_o <= (state != NFC_IDLE);
      done_o <= (state == NFC_FINISH);
    end
  end
endmodule : nfc_ctrl

//--- tb/nfc_ctrl_sva.sv
// Checker on the controller's flash pins
module nfc_ctrl_chk (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic protect_i,
  input wire logic rd_valid_o,
  input wire logic chip_enable_n_o,
  input wire logic cmd_latch_o,
  input wire logic addr_latch_o,
  input wire logic write_strobe_n_o,
  input wire logic read_strobe_n_o,
  input wire logic write_protect_n_o,
  input wire logic [7:0] io_bus_o,
  input wire logic io_bus_oe_n_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  chk_byte_held_stable: assert property (
    !write_strobe_n_o |=> $stable(cmd_latch_o) && $stable(addr_latch_o) && $stable(io_bus_o))
    else $error("latch selects or byte moved at strobe rise");
  chk_write_drives_bus: assert property (
    !write_strobe_n_o |-> !io_bus_oe_n_o && !chip_enable_n_o)
    else $error("write strobe without driven bus");
  chk_no_bus_fight: assert property (
    !read_strobe_n_o |-> io_bus_oe_n_o)
    else $error("bus driven during read strobe");
  chk_idle_bus_free: assert property (
    chip_enable_n_o |-> io_bus_oe_n_o)
    else $error("bus driven while deselected");
  chk_selects_apart: assert property (
    !(cmd_latch_o && addr_latch_o))
    else $error("both latch selects high");
  chk_strobes_apart: assert property (
    !(!read_strobe_n_o && !write_strobe_n_o))
    else $error("both strobes low");
  chk_read_cycle: assert property (
    $fell(read_strobe_n_o) |=> read_strobe_n_o [*2])
    else $error("read strobe cycle too short");
  chk_read_returns: assert property (
    $fell(read_strobe_n_o) |-> ##[1:6] rd_valid_o)
    else $error("no read byte after read strobe");
  chk_protect_follow: assert property (
    protect_i |=> !write_protect_n_o)
    else $error("write protect not driven low");
endmodule : nfc_ctrl_chk

bind nfc_ctrl nfc_ctrl_chk i_chk (.mclk_i, .sys_rst_i, .protect_i, .rd_valid_o, .chip_enable_n_o,
  .cmd_latch_o, .addr_latch_o, .write_strobe_n_o, .read_strobe_n_o, .write_protect_n_o,
  .io_bus_o, .io_bus_oe_n_o);

//--- tb/nfc_flash_model.sv
// Behavioural flash die facing the controller
module nfc_flash_model #(
  parameter int BUSY_CLKS = 12
) (
  input wire logic mclk_i,
  input wire logic chip_enable_n_o,
  input wire logic cmd_latch_o,
  input wire logic addr_latch_o,
  input wire logic write_strobe_n_o,
  input wire logic read_strobe_n_o,
  input wire logic write_protect_n_o,
  input wire logic [7:0] io_bus_o,
  input wire logic io_bus_oe_n_o,
  output logic [7:0] io_bus_i,
  output logic ready_busy_n_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] pbuf [256];
  logic [7:0] cmd = 8'hff;
  logic [7:0] col = 8'h00;
  logic [7:0] dout = 8'h00;
  logic go = 1'b0;
  logic go_seen = 1'b0;
  int acnt = 0;
  int bcnt = 0;
  initial for (int i = 0; i < 256; i++) begin
    mem[i] = 8'(i) ^ 8'h5a;
    pbuf[i] = 8'(i) ^ 8'h5a;
  end
  // One process for both strobes, so the column has a single writer
  always @(posedge write_strobe_n_o or negedge read_strobe_n_o) begin
    // Unknown select at power-up must not land a byte
    if (chip_enable_n_o !== 1'b0) begin
    end else if (!read_strobe_n_o) begin
      if (cmd == 8'h70) begin
        dout <= {7'h00, ready_busy_n_i};
      end else begin
        dout <= mem[col];
        col <= col + 8'h01;
      end
    end else if (cmd_latch_o) begin
      cmd <= io_bus_o;
      acnt <= 0;
      if (io_bus_o == 8'h30 || (write_protect_n_o && (io_bus_o == 8'h10 || io_bus_o == 8'hd0)))
        go <= ~go;
      // Only an unprotected confirm touches the array
      if (write_protect_n_o && io_bus_o == 8'h10) begin
        for (int i = 0; i < 256; i++) mem[i] <= pbuf[i];
      end
      if (write_protect_n_o && io_bus_o == 8'hd0) begin
        for (int i = 0; i < 256; i++) mem[i] <= 8'hff;
      end
    end else if (addr_latch_o) begin
      if (acnt == 0 && cmd != 8'h60) col <= io_bus_o;
      acnt <= acnt + 1;
    end else begin
      pbuf[col] <= io_bus_o;
      col <= col + 8'h01;
    end
  end
  always @(posedge mclk_i) begin
    if (go != go_seen) begin
      go_seen <= go;
      bcnt <= BUSY_CLKS;
    end else if (bcnt > 0) bcnt <= bcnt - 1;
  end
  // Busy regardless of chip enable; a floating bus shows inverted data
  assign ready_busy_n_i = (bcnt == 0) && (go == go_seen);
  assign io_bus_i = !io_bus_oe_n_o ? io_bus_o
                  : ((!chip_enable_n_o && !read_strobe_n_o) ? dout : ~dout);
endmodule : nfc_flash_model

//--- tb/test_nand_flash_pin_interface.sv
// Self-checking bench for the flash pin controller
module test_nand_flash_pin_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [39:0] addr_i = 40'h0;
  logic [15:0] len_i = 16'h0;
  logic wr_valid_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic protect_i = 1'b0;
  logic wr_ready_o, rd_valid_o, busy_o, done_o, timeout_o, chip_enable_n_o, cmd_latch_o;
  logic addr_latch_o, write_strobe_n_o, read_strobe_n_o, write_protect_n_o, io_bus_oe_n_o;
  logic ready_busy_n_i;
  logic [7:0] rd_data_o, io_bus_i, io_bus_o;
  logic [7:0] exp_q [$];
  logic [7:0] wdat [4];
  logic [39:0] a;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'h88ec;
  always #25 mclk_i = ~mclk_i;
  nfc_ctrl #(.BUSY_TIMEOUT(50)) i_dut (.mclk_i, .sys_rst_i, .start_i, .op_i, .addr_i, .len_i,
    .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .busy_o, .done_o, .timeout_o,
    .protect_i, .chip_enable_n_o, .cmd_latch_o, .addr_latch_o, .write_strobe_n_o,
    .read_strobe_n_o, .write_protect_n_o, .io_bus_i, .io_bus_o, .io_bus_oe_n_o, .ready_busy_n_i);
  nfc_flash_model #(.BUSY_CLKS(12)) i_flash (.mclk_i, .chip_enable_n_o, .cmd_latch_o,
    .addr_latch_o, .write_strobe_n_o, .read_strobe_n_o, .write_protect_n_o, .io_bus_o,
    .io_bus_oe_n_o, .io_bus_i, .ready_busy_n_i);
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic run_op(input nfc_pkg::nfc_op_e op, input int n);
    int t;
    t = 0;
    op_i <= 3'(op);
    addr_i <= a;
    len_i <= 16'(n);
    start_i <= 1'b1;
    @(posedge mclk_i);
    while (busy_o !== 1'b1 && t < 20) begin
      @(posedge mclk_i);
      t++;
    end
    start_i <= 1'b0;
    while (done_o !== 1'b1 && t < 5000) begin
      @(posedge mclk_i);
      t++;
    end
    check("done", 8'h01, {7'h00, done_o});
  endtask : run_op
  task automatic feed();
    for (int k = 0; k < 4; k++) begin
      wr_data_i <= wdat[k];
      wr_valid_i <= 1'b1;
      @(posedge mclk_i);
      while (wr_ready_o !== 1'b1) @(posedge mclk_i);
    end
    wr_valid_i <= 1'b0;
  endtask : feed
  // Results are compared in arrival order against the notes of the driver
  always @(posedge mclk_i) begin
    cyc++;
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check("rd_extra", 8'h00, 8'hff);
      else check("rd_data", exp_q.pop_front(), rd_data_o);
    end
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    a = {8'h00, 32'($random(seed))};
    for (int k = 0; k < 4; k++) exp_q.push_back((a[7:0] + 8'(k)) ^ 8'h5a);
    run_op(nfc_pkg::NFC_OP_READ, 4);
    check("timeout", 8'h00, {7'h00, timeout_o});
    for (int k = 0; k < 4; k++) wdat[k] = 8'($random(seed));
    fork
      feed();
      run_op(nfc_pkg::NFC_OP_PROGRAM, 4);
    join
    check("wp_n", 8'h01, {7'h00, write_protect_n_o});
    for (int k = 0; k < 4; k++) exp_q.push_back(wdat[k]);
    run_op(nfc_pkg::NFC_OP_READ, 4);
    run_op(nfc_pkg::NFC_OP_ERASE, 0);
    run_op(nfc_pkg::NFC_OP_RESET, 0);
    exp_q.push_back(8'h01);
    run_op(nfc_pkg::NFC_OP_STATUS, 1);
    protect_i <= 1'b1;
    for (int k = 0; k < 4; k++) wdat[k] = 8'($random(seed));
    fork
      feed();
      run_op(nfc_pkg::NFC_OP_PROGRAM, 4);
    join
    check("wp_n", 8'h00, {7'h00, write_protect_n_o});
    // Erased page must survive the locked-out program
    for (int k = 0; k < 4; k++) exp_q.push_back(8'hff);
    run_op(nfc_pkg::NFC_OP_READ, 4);
    repeat (2) @(posedge mclk_i);
    check("left", 8'h00, 8'(exp_q.size()));
    give_verdict();
  end
endmodule : test_nand_flash_pin_interface
